// [design/fsq_pkg.sv]
package fsq_pkg;
   // Command codes
   localparam logic [7:0] CMD_VERIFY = 8'h01;
   localparam logic [7:0] CMD_BYTE_WRITE = 8'h05;
   // Protected sequence values and watchdog restart code
   localparam logic [7:0] PROTECT_KEY = 8'hA5;
   localparam logic [7:0] MODE_SELF = 8'h01;
   localparam logic [7:0] MODE_SELF_INV = 8'hFE;
   localparam logic [7:0] MODE_NORMAL = 8'h00;
   localparam logic [7:0] MODE_NORMAL_INV = 8'hFF;
   localparam logic [7:0] WDT_RESTART = 8'hAC;
   // Status bit positions
   localparam int ST_PROTECT_BIT = 0;
   localparam int ST_VERIFY_BIT = 1;
   localparam int ST_WEPROT_BIT = 2;
   // Device register selects on the CPU side
   localparam logic [3:0] SEL_CMD = 4'h0;
   localparam logic [3:0] SEL_APH = 4'h1;
   localparam logic [3:0] SEL_APL = 4'h2;
   localparam logic [3:0] SEL_CMPH = 4'h3;
   localparam logic [3:0] SEL_CMPL = 4'h4;
   localparam logic [3:0] SEL_WBUF = 4'h5;
   localparam logic [3:0] SEL_STATUS = 4'h6;
   localparam logic [3:0] SEL_KEY = 4'h7;
   localparam logic [3:0] SEL_MODE = 4'h8;
   localparam logic [3:0] SEL_WDT = 4'h9;
   // Host software register offsets
   localparam logic [3:0] HOST_CTRL = 4'h0;
   localparam logic [3:0] HOST_BLOCK = 4'h1;
   localparam logic [3:0] HOST_ADDR = 4'h2;
   localparam logic [3:0] HOST_END = 4'h3;
   localparam logic [3:0] HOST_DATA = 4'h4;
   localparam logic [3:0] HOST_STAT = 4'h5;
   // Host control codes (written to HOST_CTRL)
   localparam logic [7:0] HC_ENTER = 8'h01;
   localparam logic [7:0] HC_LEAVE = 8'h02;
   localparam logic [7:0] HC_WRITE = 8'h03;
   localparam logic [7:0] HC_VERIFY = 8'h04;
   // Timing: one flash byte program in cycles
   localparam logic [7:0] PROG_CYCLES = 8'h08;
endpackage

// [design/fsq_if.sv]
`timescale 1ns/1ps
interface fsq_if;
   logic reg_wr; // CPU register write strobe
   logic [3:0] reg_sel; // Register select
   logic [7:0] reg_wdata; // Write data
   logic [7:0] status; // Flash status register value
   logic self_mode; // Self-programming mode active
   logic halt; // CPU executes HALT, one-cycle pulse
   logic busy; // Command running, CPU held halted
   modport dev (input reg_wr, reg_sel, reg_wdata, halt, output status, self_mode, busy);
   modport cpu (output reg_wr, reg_sel, reg_wdata, halt, input status, self_mode, busy);
endinterface

// [design/fsq_dev.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Write and verify only in self-programming mode
// [RULE_02] Command 05H is byte write
// [RULE_03] Write block comes from high pointer
// [RULE_04] Write byte address from low pointer
// [RULE_05] Program write buffer byte at pointers
// [RULE_06] Software clears status before each command
// [RULE_07] Software kicks watchdog with ACH first
// [RULE_08] HALT starts command; CPU resumes after
// [RULE_09] Errors reported in status bits one, two
// [RULE_10] Zero status means normal termination
// [RULE_11] Failed write: erase block, rewrite; no erase here, the failed write is only reported in status
// [RULE_12] Command 01H is internal verify
// [RULE_13] Verify block, start from pointers
// [RULE_14] Software sets high compare equal pointer
// [RULE_15] Verify through low compare, inclusive
// [RULE_16] Mode entry needs key, 01H, FEH, 01H
// [RULE_17] Sequence failure sets status bit zero
// [RULE_18] Normal mode uses 00H, FFH, 00H
// [RULE_19] Error flags stick until software clears
module fsq_dev
(
   input wire logic core_clk, // Core clock
   input wire logic sys_rst, // Synchronous reset, active high
   fsq_if.dev cpu, // CPU side
   input wire logic [3:0] prot_lo, // Lowest writable block
   output logic [3:0] flash_blk, // Flash array block
   output logic [7:0] flash_addr, // Flash array byte address
   output logic [7:0] flash_wdata, // Byte to program
   output logic flash_prog, // Program strobe
   input wire logic [7:0] flash_rdata // Array read data, combinational
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PROG = 4'b0010,
      ST_VER = 4'b0100,
      ST_DONE = 4'b1000
   } fsq_state_t;

   typedef struct packed {
      fsq_state_t st;
      logic [7:0] cmd;
      logic [7:0] aph;
      logic [7:0] apl;
      logic [7:0] cmph;
      logic [7:0] cmpl;
      logic [7:0] wbuf;
      logic [7:0] status;
      logic [1:0] seq; // Progress of protected sequence
      logic [7:0] seq_val;
      logic mode;
      logic [7:0] cnt;
      logic busy;
      logic prog;
      logic [7:0] faddr; // Array address, registered so the pin is a flop
   } fsq_dev_t;

   fsq_dev_t s_r, s_nxt;

   // Next-state logic: register writes, protected sequence, command engine
   always_comb
   begin
      // Hold everything by default; strobes fall back to zero
      s_nxt = s_r;
      s_nxt.prog = 1'b0;
      if (cpu.reg_wr && !s_r.busy)
      begin
         if (cpu.reg_sel == fsq_pkg::SEL_CMD)
            s_nxt.cmd = cpu.reg_wdata;
         else if (cpu.reg_sel == fsq_pkg::SEL_APH)
            s_nxt.aph = cpu.reg_wdata;
         else if (cpu.reg_sel == fsq_pkg::SEL_APL)
            s_nxt.apl = cpu.reg_wdata;
         else if (cpu.reg_sel == fsq_pkg::SEL_CMPH)
            s_nxt.cmph = cpu.reg_wdata;
         else if (cpu.reg_sel == fsq_pkg::SEL_CMPL)
            s_nxt.cmpl = cpu.reg_wdata;
         else if (cpu.reg_sel == fsq_pkg::SEL_WBUF)
            s_nxt.wbuf = cpu.reg_wdata;
         else if (cpu.reg_sel == fsq_pkg::SEL_STATUS)
            s_nxt.status = cpu.reg_wdata; // Only software clears flags [RULE_19]
         else if (cpu.reg_sel == fsq_pkg::SEL_KEY)
            s_nxt.seq = (cpu.reg_wdata == fsq_pkg::PROTECT_KEY) ? 2'd1 : 2'd0;
         else if (cpu.reg_sel == fsq_pkg::SEL_MODE)
         begin
            // Key, value, inverse, value; only the last write counts [RULE_16] [RULE_18]
            if (s_r.seq == 2'd1 && (cpu.reg_wdata == fsq_pkg::MODE_SELF
               || cpu.reg_wdata == fsq_pkg::MODE_NORMAL))
            begin
               s_nxt.seq = 2'd2;
               s_nxt.seq_val = cpu.reg_wdata;
            end
            else if (s_r.seq == 2'd2 && cpu.reg_wdata == ~s_r.seq_val)
               s_nxt.seq = 2'd3;
            else if (s_r.seq == 2'd3 && cpu.reg_wdata == s_r.seq_val)
            begin
               s_nxt.seq = 2'd0;
               s_nxt.mode = (s_r.seq_val == fsq_pkg::MODE_SELF);
            end
            else
            begin
               s_nxt.seq = 2'd0;
               s_nxt.status[fsq_pkg::ST_PROTECT_BIT] = 1'b1; // [RULE_17]
            end
         end
         else if (s_r.seq != 2'd0)
         begin
            // A write to SEL_WDT or an unused select breaks the sequence
            s_nxt.seq = 2'd0;
            s_nxt.status[fsq_pkg::ST_PROTECT_BIT] = 1'b1; // [RULE_17]
         end
      end
      // Command engine; a HALT outside self mode leaves it idle
      case (s_r.st)
         ST_IDLE:
         begin
            if (cpu.halt && s_r.mode) // HALT only acts in self mode [RULE_01] [RULE_08]
            begin
               s_nxt.busy = 1'b1;
               if (s_r.cmd == fsq_pkg::CMD_BYTE_WRITE) // [RULE_02]
               begin
                  if (s_r.aph[3:0] < prot_lo || s_r.aph[7:4] != 4'h0)
                  begin
                     s_nxt.status[fsq_pkg::ST_WEPROT_BIT] = 1'b1; // [RULE_09]
                     s_nxt.st = ST_DONE;
                  end
                  else
                  begin
                     s_nxt.prog = 1'b1; // [RULE_03] [RULE_04] [RULE_05]
                     s_nxt.cnt = fsq_pkg::PROG_CYCLES;
                     s_nxt.st = ST_PROG;
                  end
               end
               else if (s_r.cmd == fsq_pkg::CMD_VERIFY) // [RULE_12]
               begin
                  if (s_r.cmph != s_r.aph || s_r.cmpl < s_r.apl)
                  begin
                     s_nxt.status[fsq_pkg::ST_VERIFY_BIT] = 1'b1; // [RULE_09]
                     s_nxt.st = ST_DONE;
                  end
                  else
                  begin
                     s_nxt.cnt = s_r.apl; // [RULE_13]
                     s_nxt.st = ST_VER;
                  end
               end
               else
               begin
                  // Unknown command reports a verify/command error
                  s_nxt.status[fsq_pkg::ST_VERIFY_BIT] = 1'b1;
                  s_nxt.st = ST_DONE;
               end
            end
         end
         ST_PROG:
         begin
            s_nxt.cnt = s_r.cnt - 8'h01;
            // Readback at the last count catches a byte that did not take
            if (s_r.cnt == 8'h01)
            begin
               if (flash_rdata != s_r.wbuf)
                  s_nxt.status[fsq_pkg::ST_WEPROT_BIT] = 1'b1; // Readback mismatch [RULE_09]
               s_nxt.st = ST_DONE;
            end
         end
         ST_VER:
         begin
            // Internal verify: each byte must read back programmed (not erased)
            if (flash_rdata == 8'hFF)
               s_nxt.status[fsq_pkg::ST_VERIFY_BIT] = 1'b1; // [RULE_09]
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == s_r.cmpl) // End address inclusive [RULE_15]
               s_nxt.st = ST_DONE;
         end
         ST_DONE:
         begin
            s_nxt.busy = 1'b0; // CPU resumes after HALT [RULE_08]
            s_nxt.st = ST_IDLE;
         end
         default:
            s_nxt.st = ST_IDLE;
      endcase
      // Walk address while verifying, pointer otherwise; one cycle ahead of use
      s_nxt.faddr = (s_nxt.st == ST_VER) ? s_nxt.cnt : s_nxt.apl;
      // Synchronous reset overrides every update above
      if (sys_rst)
      begin
         s_nxt = '0;
         s_nxt.st = ST_IDLE;
      end
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      s_r <= s_nxt;
   end

   // Status zero means the command ended normally [RULE_10]
   assign cpu.status = s_r.status;
   assign cpu.self_mode = s_r.mode;
   assign cpu.busy = s_r.busy;
   assign flash_blk = s_r.aph[3:0];
   assign flash_addr = s_r.faddr;
   assign flash_wdata = s_r.wbuf;
   assign flash_prog = s_r.prog;
endmodule

// [design/fsq_cpu.sv]
`timescale 1ns/1ps
// CPU end: runs the user self-programming sequences from host register orders
module fsq_cpu
(
   input wire logic core_clk, // Core clock
   input wire logic sys_rst, // Synchronous reset, active high
   fsq_if.cpu dev, // Device side
   input wire logic [3:0] sw_addr, // Host register offset
   input wire logic [7:0] sw_wdata, // Host write data
   input wire logic sw_wr, // Host write strobe
   input wire logic sw_rd, // Host read strobe
   output logic [7:0] sw_rdata, // Host read data, cycle after strobe
   output logic wdt_kick // Watchdog restart pulse
);
   typedef enum logic [3:0] {
      CS_IDLE = 4'b0001,
      CS_WR = 4'b0010,
      CS_WAIT = 4'b0100,
      CS_CHECK = 4'b1000
   } fsq_cpu_state_t;

   typedef struct packed {
      fsq_cpu_state_t st;
      logic [7:0] op;
      logic [7:0] blk;
      logic [7:0] addr;
      logic [7:0] endaddr;
      logic [7:0] data;
      logic [7:0] result; // Last status seen, or 04H for a write or verify refused outside self mode
      logic done;
      logic [3:0] step;
      logic wr;
      logic [3:0] sel;
      logic [7:0] wd;
      logic halt;
      logic kick;
      logic [7:0] rdata;
   } fsq_cpu_s_t;

   fsq_cpu_s_t c_r, c_nxt;

   // Step table for each operation: select and value for a given step
   function automatic logic [12:0] step_entry(input logic [7:0] op, input logic [3:0] k,
                                              input logic [7:0] b, input logic [7:0] a,
                                              input logic [7:0] e, input logic [7:0] d);
      logic [12:0] r;
      logic [7:0] mv;
      logic [7:0] mi;
      r = {1'b0, 4'h0, 8'h00};
      mv = (op == fsq_pkg::HC_ENTER) ? fsq_pkg::MODE_SELF : fsq_pkg::MODE_NORMAL;
      mi = (op == fsq_pkg::HC_ENTER) ? fsq_pkg::MODE_SELF_INV : fsq_pkg::MODE_NORMAL_INV;
      if (op == fsq_pkg::HC_ENTER || op == fsq_pkg::HC_LEAVE)
      begin
         // Clear status, key, value, inverse, value [RULE_16] [RULE_18]
         if (k == 4'd0) r = {1'b1, fsq_pkg::SEL_STATUS, 8'h00};
         else if (k == 4'd1) r = {1'b1, fsq_pkg::SEL_KEY, fsq_pkg::PROTECT_KEY};
         else if (k == 4'd2) r = {1'b1, fsq_pkg::SEL_MODE, mv};
         else if (k == 4'd3) r = {1'b1, fsq_pkg::SEL_MODE, mi};
         else if (k == 4'd4) r = {1'b1, fsq_pkg::SEL_MODE, mv};
      end
      else
      begin
         if (k == 4'd0)
            r = {1'b1, fsq_pkg::SEL_CMD, (op == fsq_pkg::HC_WRITE) ?
                 fsq_pkg::CMD_BYTE_WRITE : fsq_pkg::CMD_VERIFY};
         else if (k == 4'd1) r = {1'b1, fsq_pkg::SEL_APH, b};
         else if (k == 4'd2) r = {1'b1, fsq_pkg::SEL_APL, a};
         else if (k == 4'd3) r = {1'b1, fsq_pkg::SEL_CMPH, b}; // Same as pointer [RULE_14]
         else if (k == 4'd4) r = {1'b1, fsq_pkg::SEL_CMPL, e};
         else if (k == 4'd5) r = {1'b1, fsq_pkg::SEL_WBUF, d};
         else if (k == 4'd6) r = {1'b1, fsq_pkg::SEL_STATUS, 8'h00}; // [RULE_06]
         else if (k == 4'd7) r = {1'b1, fsq_pkg::SEL_WDT, fsq_pkg::WDT_RESTART}; // [RULE_07]
      end
      return r;
   endfunction

   logic [12:0] ent;

   // Host commands, sequence stepping and status capture
   always_comb
   begin
      ent = step_entry(c_r.op, c_r.step, c_r.blk, c_r.addr, c_r.endaddr, c_r.data);
      c_nxt = c_r;
      c_nxt.wr = 1'b0;
      c_nxt.halt = 1'b0;
      c_nxt.kick = 1'b0;
      c_nxt.rdata = 8'h00;
      if (sw_rd)
      begin
         if (sw_addr == fsq_pkg::HOST_STAT)
            c_nxt.rdata = {dev.busy, dev.self_mode, (c_r.st != CS_IDLE), c_r.done,
                           1'b0, c_r.result[2:0]};
         else if (sw_addr == fsq_pkg::HOST_BLOCK)
            c_nxt.rdata = c_r.blk;
         else if (sw_addr == fsq_pkg::HOST_ADDR)
            c_nxt.rdata = c_r.addr;
         else if (sw_addr == fsq_pkg::HOST_END)
            c_nxt.rdata = c_r.endaddr;
         else if (sw_addr == fsq_pkg::HOST_DATA)
            c_nxt.rdata = c_r.data;
      end
      case (c_r.st)
         CS_IDLE:
         begin
            if (sw_wr)
            begin
               if (sw_addr == fsq_pkg::HOST_BLOCK) c_nxt.blk = sw_wdata;
               else if (sw_addr == fsq_pkg::HOST_ADDR) c_nxt.addr = sw_wdata;
               else if (sw_addr == fsq_pkg::HOST_END) c_nxt.endaddr = sw_wdata;
               else if (sw_addr == fsq_pkg::HOST_DATA) c_nxt.data = sw_wdata;
               else if (sw_addr == fsq_pkg::HOST_CTRL && sw_wdata >= fsq_pkg::HC_ENTER
                        && sw_wdata <= fsq_pkg::HC_VERIFY)
               begin
                  // Write and verify refused outside self mode [RULE_01]
                  if ((sw_wdata == fsq_pkg::HC_WRITE || sw_wdata == fsq_pkg::HC_VERIFY)
                      && !dev.self_mode)
                     c_nxt.result = 8'h04;
                  else
                  begin
                     c_nxt.op = sw_wdata;
                     c_nxt.step = 4'd0;
                     c_nxt.done = 1'b0;
                     c_nxt.st = CS_WR;
                  end
               end
            end
         end
         CS_WR:
         begin
            c_nxt.wr = ent[12];
            c_nxt.sel = ent[11:8];
            c_nxt.wd = ent[7:0];
            c_nxt.kick = ent[12] && (ent[11:8] == fsq_pkg::SEL_WDT);
            c_nxt.step = c_r.step + 4'd1;
            if (!ent[12])
            begin
               c_nxt.st = CS_WAIT;
               // HALT starts write or verify [RULE_08]
               c_nxt.halt = (c_r.op == fsq_pkg::HC_WRITE || c_r.op == fsq_pkg::HC_VERIFY);
               c_nxt.step = 4'd0;
            end
         end
         CS_WAIT:
         begin
            // Two cycles let the halt reach the device and busy come back
            c_nxt.step = c_r.step + 4'd1;
            if (c_r.step >= 4'd2 && !dev.busy)
               c_nxt.st = CS_CHECK;
         end
         CS_CHECK:
         begin
            // Any nonzero status is abnormal; a failed write needs erase [RULE_10] [RULE_11]
            c_nxt.result = dev.status;
            c_nxt.done = 1'b1;
            c_nxt.st = CS_IDLE;
         end
         default:
            c_nxt.st = CS_IDLE;
      endcase
      if (sys_rst)
      begin
         c_nxt = '0;
         c_nxt.st = CS_IDLE;
      end
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      c_r <= c_nxt;
   end

   assign dev.reg_wr = c_r.wr;
   assign dev.reg_sel = c_r.sel;
   assign dev.reg_wdata = c_r.wd;
   assign dev.halt = c_r.halt;
   assign sw_rdata = c_r.rdata;
   assign wdt_kick = c_r.kick;
endmodule

// [verification/fsq_link_props.sv]
`timescale 1ns/1ps
// Watches the link between the CPU end and the device end
module fsq_link_props
(
   input wire logic core_clk, // Core clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic reg_wr, // Register write strobe
   input wire logic [3:0] reg_sel, // Register select
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic [7:0] status, // Status register
   input wire logic self_mode, // Mode flag
   input wire logic halt, // Halt pulse
   input wire logic busy // Command running
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // A command only runs when started by a halt inside the mode
   a_busy_needs_halt: assert property ($rose(busy) |-> $past(halt) && self_mode)
      else $error("busy rose without halt in mode");
   // An error may stand in for busy when the orders are refused at once
   a_halt_starts: assert property (halt && self_mode && !busy |=> busy || (|status[2:1]))
      else $error("halt in mode did not start the command");
   a_busy_ends: assert property ($rose(busy) |-> ##[1:1000] !busy)
      else $error("command never completed");
   a_mode_enter: assert property ($rose(self_mode) |-> $past(reg_wr &&
      reg_sel == fsq_pkg::SEL_MODE && reg_wdata == fsq_pkg::MODE_SELF))
      else $error("mode entered without final mode write");
   a_mode_leave: assert property ($fell(self_mode) |-> $past(reg_wr &&
      reg_sel == fsq_pkg::SEL_MODE && reg_wdata == fsq_pkg::MODE_NORMAL))
      else $error("mode left without final normal write");
   a_flags_sticky: assert property ((|($past(status) & ~status)) |->
      $past(reg_wr && reg_sel == fsq_pkg::SEL_STATUS))
      else $error("status flag cleared without a status write");
   a_verify_cause: assert property ($rose(status[fsq_pkg::ST_VERIFY_BIT]) |->
      $past(busy || halt))
      else $error("verify flag set outside a command");
   a_protect_cause: assert property ($rose(status[fsq_pkg::ST_PROTECT_BIT]) |->
      $past(reg_wr))
      else $error("sequence flag set without a register write");
   a_status_clear: assert property (reg_wr && reg_sel == fsq_pkg::SEL_STATUS &&
      reg_wdata == 8'h00 && !busy && !halt |=> status == 8'h00)
      else $error("status write did not clear the flags");
endmodule

// [verification/flash_self_prog_write_verify_bench.sv]
`timescale 1ns/1ps
// Joins both ends, drives the host port and checks the results
module flash_self_prog_write_verify_bench;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic chk = 1'b0;
   logic chk_d = 1'b0;
   logic [7:0] sw_rdata;
   logic wdt_kick;
   logic [3:0] flash_blk;
   logic [7:0] flash_addr;
   logic [7:0] flash_wdata;
   logic flash_prog;
   logic [7:0] mem [0:4095];
   logic [7:0] last_cmd = 8'h00;
   logic [15:0] rq [$];
   logic [19:0] pq [$];
   logic [7:0] cq [$];
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int wdt_n = 0;
   int kick_n = 0;
   logic [31:0] seed = 32'hB013;
   fsq_if bus ();
   fsq_if bif ();

   always #2 core_clk = ~core_clk;

   fsq_cpu fsq_cpu_i (.core_clk(core_clk), .sys_rst(sys_rst), .dev(bus), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .wdt_kick(wdt_kick));
   fsq_dev fsq_dev_i (.core_clk(core_clk), .sys_rst(sys_rst), .cpu(bus), .prot_lo(4'h2),
      .flash_blk(flash_blk), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
      .flash_prog(flash_prog), .flash_rdata(mem[{flash_blk, flash_addr}]));
   // Second device end, driven by hand to break the software rules
   fsq_dev fsq_dev_i2 (.core_clk(core_clk), .sys_rst(sys_rst), .cpu(bif), .prot_lo(4'h2),
      .flash_blk(), .flash_addr(), .flash_wdata(), .flash_prog(), .flash_rdata(8'h00));
   fsq_link_props fsq_link_props_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(bus.reg_wr),
      .reg_sel(bus.reg_sel), .reg_wdata(bus.reg_wdata), .status(bus.status),
      .self_mode(bus.self_mode), .halt(bus.halt), .busy(bus.busy));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_prog(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Host write, one strobe cycle
   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge core_clk);
      sw_wr <= 1'b0;
   endtask

   // Status read; data stands only in the cycle after the strobe
   task automatic hr(output logic [7:0] d, input logic c);
      @(posedge core_clk);
      sw_addr <= fsq_pkg::HOST_STAT;
      sw_rd <= 1'b1;
      chk <= c;
      @(posedge core_clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask

   task automatic hchk(input logic [7:0] e, input logic [7:0] m);
      logic [7:0] d;
      rq.push_back({e, m});
      hr(d, 1'b1);
   endtask

   // Polls until neither busy nor running; the cycle limit catches a hang
   task automatic cmd(input logic [7:0] c, input logic [7:0] b, input logic [7:0] a,
      input logic [7:0] e, input logic [7:0] d);
      logic [7:0] s;
      hw(fsq_pkg::HOST_BLOCK, b);
      hw(fsq_pkg::HOST_ADDR, a);
      hw(fsq_pkg::HOST_END, e);
      hw(fsq_pkg::HOST_DATA, d);
      hw(fsq_pkg::HOST_CTRL, c);
      repeat (3) @(posedge core_clk);
      s = 8'hA0;
      while ((s & 8'hA0) !== 8'h00)
         hr(s, 1'b0);
   endtask

   task automatic bw(input logic [3:0] s, input logic [7:0] d, input logic h);
      @(posedge core_clk);
      bif.reg_sel <= s;
      bif.reg_wdata <= d;
      bif.reg_wr <= !h;
      bif.halt <= h;
      @(posedge core_clk);
      bif.reg_wr <= 1'b0;
      bif.halt <= 1'b0;
   endtask

   task automatic bseq(input logic [7:0] m2);
      bw(fsq_pkg::SEL_STATUS, 8'h00, 1'b0);
      bw(fsq_pkg::SEL_KEY, fsq_pkg::PROTECT_KEY, 1'b0);
      bw(fsq_pkg::SEL_MODE, fsq_pkg::MODE_SELF, 1'b0);
      bw(fsq_pkg::SEL_MODE, m2, 1'b0);
      bw(fsq_pkg::SEL_MODE, fsq_pkg::MODE_SELF, 1'b0);
      #1;
   endtask

   task automatic bver(input logic [7:0] ch);
      bw(fsq_pkg::SEL_CMD, fsq_pkg::CMD_VERIFY, 1'b0);
      bw(fsq_pkg::SEL_APH, 8'h03, 1'b0);
      bw(fsq_pkg::SEL_APL, 8'h00, 1'b0);
      bw(fsq_pkg::SEL_CMPH, ch, 1'b0);
      bw(fsq_pkg::SEL_CMPL, 8'h05, 1'b0);
      bw(fsq_pkg::SEL_STATUS, 8'h00, 1'b0);
      bw(4'h0, 8'h00, 1'b1);
      repeat (3) @(posedge core_clk);
      while (bif.busy !== 1'b0)
         @(posedge core_clk);
      #1;
   endtask

   // Result watcher: status reads, flash programming, orders on the link
   always @(posedge core_clk)
   begin
      logic [15:0] e;
      cycles++;
      if (chk_d)
      begin
         e = rq.pop_front();
         cmp8(sw_rdata & e[7:0], e[15:8]);
      end
      chk_d <= sw_rd && chk;
      if (flash_prog)
      begin
         mem[{flash_blk, flash_addr}] <= flash_wdata;
         cmp_prog({flash_blk, flash_addr, flash_wdata}, pq.size() ? pq.pop_front() : 20'hFFFFF);
      end
      if (bus.reg_wr && bus.reg_sel === fsq_pkg::SEL_CMD)
         last_cmd <= bus.reg_wdata;
      if (bus.halt)
         cmp8(last_cmd, cq.size() ? cq.pop_front() : 8'hEE);
      if (bus.reg_wr && bus.reg_sel === fsq_pkg::SEL_WDT && bus.reg_wdata === 8'hAC)
         wdt_n++;
      if (wdt_kick)
         kick_n++;
      if (cycles > 30000)
      begin
         miscompares++;
         end_of_test();
      end
   end

   initial
   begin
      logic [7:0] b;
      logic [7:0] a;
      logic [23:0] vt [5];
      bif.reg_wr = 1'b0;
      bif.reg_sel = 4'h0;
      bif.reg_wdata = 8'h00;
      bif.halt = 1'b0;
      vt = '{24'h102040, 24'h102142, 24'h212142, 24'h223040, 24'h222142};
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'h00;
      mem[12'h021] = 8'hFF;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      cmd(fsq_pkg::HC_WRITE, 8'h05, 8'h20, 8'h20, 8'h10);
      hchk(8'h04, 8'h47);
      cmd(fsq_pkg::HC_ENTER, 8'h00, 8'h00, 8'h00, 8'h00);
      hchk(8'h40, 8'h47);
      cq.push_back(fsq_pkg::CMD_BYTE_WRITE);
      cmd(fsq_pkg::HC_WRITE, 8'h01, 8'h20, 8'h20, 8'h10);
      // A failed write is not retried in place; the bench moves on
      hchk(8'h44, 8'h47);
      $display("test mode and refusals ended");
      for (int i = 0; i < 6; i++)
      begin
         b = (i == 0) ? 8'h02 : 8'h02 + 8'(rnd() % 32'd14);
         a = 8'(rnd());
         pq.push_back({b[3:0], a, 8'(seed >> 8)});
         cq.push_back(fsq_pkg::CMD_BYTE_WRITE);
         cmd(fsq_pkg::HC_WRITE, b, a, a, 8'(seed >> 8));
         hchk(8'h40, 8'h47);
      end
      $display("test byte writes ended");
      for (int i = 0; i < 5; i++)
      begin
         cq.push_back(fsq_pkg::CMD_VERIFY);
         cmd(fsq_pkg::HC_VERIFY, 8'h00, vt[i][23:16], vt[i][15:8], 8'h00);
         hchk(vt[i][7:0], 8'h47);
      end
      $display("test verify ended");
      cmd(fsq_pkg::HC_LEAVE, 8'h00, 8'h00, 8'h00, 8'h00);
      hchk(8'h00, 8'h47);
      cmd(fsq_pkg::HC_WRITE, 8'h02, 8'h20, 8'h20, 8'h10);
      hchk(8'h04, 8'h47);
      repeat (3) @(posedge core_clk);
      cmp8(8'(wdt_n), 8'd12);
      cmp8(8'(kick_n), 8'd12);
      cmp8(8'(pq.size() + cq.size() + rq.size()), 8'h00);
      $display("test link counts ended");
      bw(4'h0, 8'h00, 1'b1);
      repeat (3) @(posedge core_clk);
      #1 cmp8({7'h00, bif.busy}, 8'h00);
      bseq(fsq_pkg::MODE_SELF);
      cmp8({6'h00, bif.self_mode, bif.status[0]}, 8'h01);
      bseq(fsq_pkg::MODE_SELF_INV);
      cmp8({6'h00, bif.self_mode, bif.status[0]}, 8'h02);
      bver(8'h04);
      cmp8(bif.status & 8'h06, 8'h02);
      bver(8'h03);
      cmp8(bif.status, 8'h00);
      // An unknown command code must end at once with the command error flag
      bw(fsq_pkg::SEL_CMD, 8'h07, 1'b0);
      bw(4'h0, 8'h00, 1'b1);
      repeat (3) @(posedge core_clk);
      #1 cmp8(bif.status, 8'h02);
      $display("test software faults ended");
      end_of_test();
   end
endmodule
